//--- core/path_framer_cfg.svh
/*
 Constants of the path packet framer and router: register offsets, field
 positions, limits, response codes and fixed header codes.
 Assumes inclusion by bare name from the framer's design files.
*/
`ifndef PATH_FRAMER_CFG_SVH
`define PATH_FRAMER_CFG_SVH

`define REG_CTRL 8'h00
`define REG_ROUTE 8'h04
`define REG_SAPS 8'h08
`define REG_STATUS 8'h0C

`define CTRL_TYPE_BIT 8
`define ROUTE_VALID_BIT 31
`define ROUTE_SRC_OCTET_BIT 30
`define ROUTE_DST_OCTET_BIT 29
`define ROUTE_QUAL_EN_BIT 28
`define ROUTE_QUAL_LSB 20
`define SAPS_ENTRY_LSB 16

`define HDR_VERSION 3'h0
`define SEQ_UNSEGMENTED 2'h3
`define APP_ID_RESERVED_BASE 11'h7F0
`define MAX_OCTETS 17'h10000

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- core/path_framer_pkg.sv
/*
 Types of the path packet framer and router: header layout, request and
 indication bundles, route entry and sequencing states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package path_framer_pkg;

	// Primary header, most significant field first as on the wire.
	typedef struct packed {
		logic [2:0] version;
		logic type_bit;
		logic second_header_present;
		logic [10:0] app_process_ident;
		logic [1:0] seq_flags;
		logic [13:0] seq_count;
		logic [15:0] length;
	} path_hdr_t;

	// Assembly request: user header plus octets that follow the header.
	typedef struct packed {
		path_hdr_t user_hdr;
		logic [16:0] octet_count;
	} asm_req_t;

	// Transmitted header with the set of exit access points.
	typedef struct packed {
		path_hdr_t hdr;
		logic [15:0] sap_mask;
	} tx_out_t;

	// Arrival indication toward user or extraction.
	typedef struct packed {
		logic to_extract;
		logic [18:0] path_identifier;
		logic data_loss;
		path_hdr_t hdr;
	} rx_ind_t;

	// One logical data path in the routing list.
	typedef struct packed {
		logic valid;
		logic src_octet;
		logic dst_octet;
		logic qual_en;
		logic [7:0] qualifier;
		logic [10:0] app_process_ident;
		logic [3:0] entry_sap;
		logic [15:0] exit_mask;
	} route_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOOK = 2'b01,
		ST_SEND = 2'b10
	} stage_t;

endpackage

//--- core/path_packet_framer_router.sv
/*
 Path packet framer and router: builds primary headers for outgoing packets,
 selects exit access points, recovers the path of arriving packets and
 checks sequence continuity for extraction. Routes are set over AXI4-Lite.
 Assumes request and answer ports are driven from logic on aclk.
*/
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "path_framer_cfg.svh"

module path_packet_framer_router #(
	parameter int NUM_ROUTES = 8,
	parameter int NUM_SAP = 4
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels.
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Assembly requests from the user.
	input wire logic asm_valid,
	output logic asm_ready,
	input wire path_framer_pkg::asm_req_t asm_req,
	output logic asm_refused,
	// Outgoing headers toward the access points.
	output logic tx_valid,
	input wire logic tx_ready,
	output path_framer_pkg::tx_out_t tx_out,
	// Arriving headers from the access points.
	input wire logic rx_valid,
	output logic rx_ready,
	input wire path_framer_pkg::path_hdr_t rx_hdr,
	input wire logic [3:0] rx_sap,
	output logic rx_dropped,
	// Indications toward the user or extraction.
	output logic ind_valid,
	input wire logic ind_ready,
	output path_framer_pkg::rx_ind_t ind_out
);
	import path_framer_pkg::*;

	localparam int IDX_W = (NUM_ROUTES > 1) ? $clog2(NUM_ROUTES) : 1;

	route_t route_r [NUM_ROUTES];
	logic [IDX_W-1:0] route_sel_r;
	logic type_bit_r;
	logic [7:0] tx_cnt_r, rx_cnt_r, loss_cnt_r, refused_cnt_r;

	logic aw_have_r, w_have_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic do_write, wr_ok;
	logic [31:0] wmask, route_word, saps_word, ctrl_word, status_word, merged;
	logic [31:0] rd_mux;
	logic rd_ok;
	route_t sel_route;

	stage_t tx_state_r, rx_state_r;
	asm_req_t req_r;
	logic [IDX_W-1:0] tx_idx, tx_idx_r, rx_idx, rx_idx_r;
	logic tx_hit, rx_hit, tx_len_ok;
	logic [13:0] tx_seq_rd;
	logic [14:0] rx_seq_rd;
	logic tx_wr_en, rx_wr_en;
	path_hdr_t rx_hdr_r;
	logic [7:0] rx_qual, rx_qual_r;

	// Register views of the selected route and of the block state.
	always_comb begin
		sel_route = route_r[route_sel_r];
		ctrl_word = '0;
		ctrl_word[IDX_W-1:0] = route_sel_r;
		ctrl_word[`CTRL_TYPE_BIT] = type_bit_r;
		route_word = '0;
		route_word[`ROUTE_VALID_BIT] = sel_route.valid;
		route_word[`ROUTE_SRC_OCTET_BIT] = sel_route.src_octet;
		route_word[`ROUTE_DST_OCTET_BIT] = sel_route.dst_octet;
		route_word[`ROUTE_QUAL_EN_BIT] = sel_route.qual_en;
		route_word[`ROUTE_QUAL_LSB +: 8] = sel_route.qualifier;
		route_word[10:0] = sel_route.app_process_ident;
		saps_word = '0;
		saps_word[`SAPS_ENTRY_LSB +: 4] = sel_route.entry_sap;
		saps_word[NUM_SAP-1:0] = sel_route.exit_mask[NUM_SAP-1:0];
		status_word = {refused_cnt_r, loss_cnt_r, tx_cnt_r, rx_cnt_r};
	end

	// Byte-lane mask from the latched write strobes.
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{w_strb_r[b]}};
		end
		unique case (aw_addr_r)
			`REG_CTRL: merged = (ctrl_word & ~wmask) | (w_data_r & wmask);
			`REG_ROUTE: merged = (route_word & ~wmask) | (w_data_r & wmask);
			`REG_SAPS: merged = (saps_word & ~wmask) | (w_data_r & wmask);
			default: merged = w_data_r;
		endcase
	end

	// A write completes once address and data are both held.
	assign awready = !aw_have_r && !bvalid;
	assign wready = !w_have_r && !bvalid;
	assign do_write = aw_have_r && w_have_r && !bvalid;

	// Reserved identifiers may not be given to a valid path.
	always_comb begin
		unique case (aw_addr_r)
			`REG_CTRL, `REG_SAPS: wr_ok = 1'b1;
			`REG_ROUTE: wr_ok = !(merged[`ROUTE_VALID_BIT] &&
				(merged[10:0] >= `APP_ID_RESERVED_BASE));
			default: wr_ok = 1'b0;
		endcase
	end

	// Write address and data capture.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= {awaddr[7:2], 2'b00};
			end else if (do_write) begin
				aw_have_r <= 1'b0;
			end
			if (wvalid && wready) begin
				w_have_r <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end else if (do_write) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// Write response; unmapped or refused writes answer with a slave error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Control register and routing list; all paths invalid after reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			route_sel_r <= '0;
			type_bit_r <= 1'b0;
			for (int i = 0; i < NUM_ROUTES; i++) begin
				route_r[i] <= '0;
			end
		end else if (do_write && wr_ok) begin
			unique case (aw_addr_r)
				`REG_CTRL: begin
					route_sel_r <= merged[IDX_W-1:0];
					type_bit_r <= merged[`CTRL_TYPE_BIT];
				end
				`REG_ROUTE: begin
					route_r[route_sel_r].valid <= merged[`ROUTE_VALID_BIT];
					route_r[route_sel_r].src_octet <= merged[`ROUTE_SRC_OCTET_BIT];
					route_r[route_sel_r].dst_octet <= merged[`ROUTE_DST_OCTET_BIT];
					route_r[route_sel_r].qual_en <= merged[`ROUTE_QUAL_EN_BIT];
					route_r[route_sel_r].qualifier <= merged[`ROUTE_QUAL_LSB +: 8];
					route_r[route_sel_r].app_process_ident <= merged[10:0];
				end
				`REG_SAPS: begin
					route_r[route_sel_r].entry_sap <= merged[`SAPS_ENTRY_LSB +: 4];
					route_r[route_sel_r].exit_mask <= {{(16-NUM_SAP){1'b0}}, merged[NUM_SAP-1:0]};
				end
				default: begin
				end
			endcase
		end
	end

	// Read decode.
	always_comb begin
		rd_ok = 1'b1;
		unique case ({araddr[7:2], 2'b00})
			`REG_CTRL: rd_mux = ctrl_word;
			`REG_ROUTE: rd_mux = route_word;
			`REG_SAPS: rd_mux = saps_word;
			`REG_STATUS: rd_mux = status_word;
			default: begin
				rd_mux = '0;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Read answer one cycle after the address is taken.
	assign arready = !rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// Source lookup by process identifier, lowest entry first.
	always_comb begin
		tx_hit = 1'b0;
		tx_idx = '0;
		for (int i = 0; i < NUM_ROUTES; i++) begin
			if (!tx_hit && route_r[i].valid &&
				route_r[i].app_process_ident == asm_req.user_hdr.app_process_ident) begin
				tx_hit = 1'b1;
				tx_idx = IDX_W'(i);
			end
		end
		tx_len_ok = (asm_req.octet_count != '0) && (asm_req.octet_count <= `MAX_OCTETS);
	end

	assign asm_ready = (tx_state_r == ST_IDLE);
	assign tx_valid = (tx_state_r == ST_SEND);
	assign tx_wr_en = tx_valid && tx_ready && route_r[tx_idx_r].src_octet;

	// Per-path counters for the assembly side.
	path_seq_mem #(.WIDTH(14), .DEPTH(NUM_ROUTES), .AW(IDX_W)) tx_seq_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.rd_addr(tx_idx),
		.rd_data(tx_seq_rd),
		.wr_en(tx_wr_en),
		.wr_addr(tx_idx_r),
		.wr_data(14'(tx_out.hdr.seq_count + 14'h0001))
	);

	// Assembly sequencer: take, build header, hand to access points.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_r <= ST_IDLE;
			tx_idx_r <= '0;
			req_r <= '0;
			tx_out <= '0;
			asm_refused <= 1'b0;
		end else begin
			asm_refused <= 1'b0;
			unique case (tx_state_r)
				ST_IDLE: begin
					if (asm_valid) begin
						if (tx_hit && tx_len_ok) begin
							tx_idx_r <= tx_idx;
							req_r <= asm_req;
							tx_state_r <= ST_LOOK;
						end else begin
							asm_refused <= 1'b1;
						end
					end
				end
				ST_LOOK: begin
					tx_out.hdr.version <= `HDR_VERSION;
					tx_out.hdr.second_header_present <= req_r.user_hdr.second_header_present;
					tx_out.hdr.app_process_ident <= req_r.user_hdr.app_process_ident;
					tx_out.sap_mask <= route_r[tx_idx_r].exit_mask;
					if (route_r[tx_idx_r].src_octet) begin
						tx_out.hdr.type_bit <= type_bit_r;
						tx_out.hdr.seq_flags <= `SEQ_UNSEGMENTED;
						tx_out.hdr.seq_count <= tx_seq_rd;
						tx_out.hdr.length <= 16'(req_r.octet_count - 17'h00001);
					end else begin
						tx_out.hdr.type_bit <= req_r.user_hdr.type_bit;
						tx_out.hdr.seq_flags <= req_r.user_hdr.seq_flags;
						tx_out.hdr.seq_count <= req_r.user_hdr.seq_count;
						tx_out.hdr.length <= req_r.user_hdr.length;
					end
					tx_state_r <= ST_SEND;
				end
				ST_SEND: begin
					if (tx_ready) begin
						tx_state_r <= ST_IDLE;
					end
				end
				default: tx_state_r <= ST_IDLE;
			endcase
		end
	end

	// Destination lookup; a qualifier comes from the receiving access point.
	always_comb begin
		rx_hit = 1'b0;
		rx_idx = '0;
		rx_qual = {4'h0, rx_sap};
		for (int i = 0; i < NUM_ROUTES; i++) begin
			if (!rx_hit && route_r[i].valid &&
				route_r[i].app_process_ident == rx_hdr.app_process_ident &&
				(!route_r[i].qual_en || route_r[i].qualifier == rx_qual)) begin
				rx_hit = 1'b1;
				rx_idx = IDX_W'(i);
			end
		end
	end

	assign rx_ready = (rx_state_r == ST_IDLE);
	assign ind_valid = (rx_state_r == ST_SEND);
	assign rx_wr_en = ind_valid && ind_ready;

	// Last count seen per path, with a seen bit on top.
	path_seq_mem #(.WIDTH(15), .DEPTH(NUM_ROUTES), .AW(IDX_W)) rx_seq_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.rd_addr(rx_idx),
		.rd_data(rx_seq_rd),
		.wr_en(rx_wr_en),
		.wr_addr(rx_idx_r),
		.wr_data({1'b1, ind_out.hdr.seq_count})
	);

	// Recovery sequencer: match path, check continuity, deliver.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_r <= ST_IDLE;
			rx_idx_r <= '0;
			rx_hdr_r <= '0;
			rx_qual_r <= '0;
			ind_out <= '0;
			rx_dropped <= 1'b0;
		end else begin
			rx_dropped <= 1'b0;
			unique case (rx_state_r)
				ST_IDLE: begin
					if (rx_valid) begin
						if (rx_hit) begin
							rx_idx_r <= rx_idx;
							rx_hdr_r <= rx_hdr;
							rx_qual_r <= rx_qual;
							rx_state_r <= ST_LOOK;
						end else begin
							rx_dropped <= 1'b1;
						end
					end
				end
				ST_LOOK: begin
					ind_out.to_extract <= route_r[rx_idx_r].dst_octet;
					ind_out.path_identifier <= {route_r[rx_idx_r].qual_en ? rx_qual_r : 8'h00,
						rx_hdr_r.app_process_ident};
					ind_out.hdr <= rx_hdr_r;
					ind_out.data_loss <= route_r[rx_idx_r].dst_octet && rx_seq_rd[14] &&
						(rx_hdr_r.seq_count != 14'(rx_seq_rd[13:0] + 14'h0001));
					rx_state_r <= ST_SEND;
				end
				ST_SEND: begin
					if (ind_ready) begin
						rx_state_r <= ST_IDLE;
					end
				end
				default: rx_state_r <= ST_IDLE;
			endcase
		end
	end

	// Status counters, each wrapping at eight bits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_cnt_r <= '0;
			rx_cnt_r <= '0;
			loss_cnt_r <= '0;
			refused_cnt_r <= '0;
		end else begin
			if (tx_valid && tx_ready) begin
				tx_cnt_r <= tx_cnt_r + 8'h01;
			end
			if (rx_wr_en) begin
				rx_cnt_r <= rx_cnt_r + 8'h01;
			end
			if (rx_wr_en && ind_out.data_loss) begin
				loss_cnt_r <= loss_cnt_r + 8'h01;
			end
			if (asm_refused || rx_dropped) begin
				refused_cnt_r <= refused_cnt_r + {7'h00, asm_refused} + {7'h00, rx_dropped};
			end
		end
	end

endmodule // path_packet_framer_router

`default_nettype wire

//--- core/path_seq_mem.sv
/*
 Small per-path memory for sequence counts with a registered read port.
 Assumes one clock and a synchronous active-low reset that clears all words.
*/
`timescale 1ns/1ps
`default_nettype none

module path_seq_mem #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Read port.
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data,
	// Write port.
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data
);

	logic [WIDTH-1:0] mem_r [DEPTH];

	// Storage; every word starts from zero after reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	// Read data come out of a register one cycle after the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem_r[rd_addr];
		end
	end

endmodule // path_seq_mem

`default_nettype wire

//--- verification/path_framer_sva.sv
/* Port checker of the path packet framer and router.
 Assumes one clock and a bind onto the top module. */
`timescale 1ns/1ps
`default_nettype none
module path_framer_check (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register write handshakes.
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	// Assembly side.
	input wire logic asm_valid,
	input wire logic asm_ready,
	input wire logic asm_refused,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire path_framer_pkg::tx_out_t tx_out,
	// Recovery side.
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire path_framer_pkg::path_hdr_t rx_hdr,
	input wire logic rx_dropped,
	input wire logic ind_valid,
	input wire path_framer_pkg::rx_ind_t ind_out
);
	import path_framer_pkg::*;
	path_hdr_t rx_hdr_r;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Keeps the header taken from the access point for comparison.
	always_ff @(posedge aclk) begin
		if (rx_valid && rx_ready) rx_hdr_r <= rx_hdr;
	end
	a_version_zero: assert property (tx_valid |-> tx_out.hdr.version == 3'h0)
		else $error("Outgoing version not zero.");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_out))
		else $error("Outgoing header changed while stalled.");
	a_busy_tx: assert property (tx_valid |-> !asm_ready)
		else $error("Assembly ready while sending.");
	a_asm_answer: assert property (asm_valid && asm_ready |-> ##1 asm_refused or ##2 tx_valid)
		else $error("Assembly answer late or missing.");
	a_rx_answer: assert property (rx_valid && rx_ready |-> ##1 rx_dropped or ##2 ind_valid)
		else $error("Arrival answer late or missing.");
	a_packet_intact: assert property (ind_valid && !ind_out.to_extract |-> ind_out.hdr == rx_hdr_r)
		else $error("Delivered packet altered.");
	a_path_join: assert property (ind_valid |->
		ind_out.path_identifier[10:0] == ind_out.hdr.app_process_ident)
		else $error("Path identifier lacks process identifier.");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("Write response late.");
	a_reset_idle: assert property ($rose(aresetn) |-> !tx_valid && !ind_valid && !bvalid && asm_ready)
		else $error("Outputs not idle after reset.");
	c_tx: cover property (tx_valid && tx_ready);
	c_loss: cover property (ind_valid && ind_out.data_loss);
	c_refused: cover property (asm_refused);
	c_dropped: cover property (rx_dropped);
endmodule // path_framer_check
bind path_packet_framer_router path_framer_check chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .asm_valid, .asm_ready, .asm_refused, .tx_valid, .tx_ready, .tx_out,
	.rx_valid, .rx_ready, .rx_hdr, .rx_dropped, .ind_valid, .ind_out);
`default_nettype wire

//--- verification/path_sap_model.sv
/* Access points and user that take outgoing headers and indications.
 Assumes the bench chooses prompt or stalling behaviour. */
`timescale 1ns/1ps
`default_nettype none
module path_sap_model (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Pacing: high stalls three cycles in four.
	input wire logic slow,
	// Readiness toward the framer.
	output logic tx_ready,
	output logic ind_ready
);
	logic [1:0] tick_r;
	// Free cycle count that paces the slow mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) tick_r <= 2'h0;
		else tick_r <= tick_r + 2'h1;
	end
	// The two sinks accept in different phases of the count.
	assign tx_ready = !slow || (tick_r == 2'h0);
	assign ind_ready = !slow || (tick_r == 2'h2);
endmodule // path_sap_model
`default_nettype wire

//--- verification/test_path_packet_framer_router.sv
/* Self-checking bench of the path packet framer and router.
 Assumes the design, its package, its header and the access point model. */
`timescale 1ns/1ps
`default_nettype none
`include "path_framer_cfg.svh"
module test_path_packet_framer_router;
	import path_framer_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, asm_valid, rx_valid, slow;
	logic awready, wready, bvalid, arready, rvalid, asm_ready, asm_refused, tx_valid, tx_ready;
	logic rx_ready, rx_dropped, ind_valid, ind_ready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, rx_sap;
	logic [1:0] bresp, rresp;
	logic [16:0] oc;
	asm_req_t asm_req;
	tx_out_t tx_out;
	path_hdr_t rx_hdr, h, eh;
	rx_ind_t ind_out;
	int num_errors, cmp_count, cycles, seed, seq_a, n_tx, n_loss;
	int sq[5] = '{5, 6, 9, 16383, 0};
	path_packet_framer_router uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .asm_valid, .asm_ready, .asm_req, .asm_refused, .tx_valid, .tx_ready,
		.tx_out, .rx_valid, .rx_ready, .rx_hdr, .rx_sap, .rx_dropped, .ind_valid, .ind_ready,
		.ind_out);
	path_sap_model sap (.aclk, .aresetn, .slow, .tx_ready, .ind_ready);
	// Free running clock of 8 ns.
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Counts every comparison and reports a difference at once.
	task automatic chk(input string name, input logic [71:0] seen, input logic [71:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Register write; each channel drops valid once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		// Ready stays high so a following write never toggles it in one step.
		chk("bresp", bresp, er);
	endtask
	// Register read.
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		chk("rdata", rdata, ed);
		chk("rresp", rresp, er);
	endtask
	// Assembly request, then the refusal or the outgoing header.
	task automatic asm(input path_hdr_t uh, input logic [16:0] n, input logic bad,
		input path_hdr_t xh, input logic [15:0] xm);
		asm_req <= '{uh, n};
		asm_valid <= 1'b1;
		do @(posedge aclk); while (!asm_ready);
		asm_valid <= 1'b0;
		asm_req <= '{~uh, ~n};
		repeat (40) begin
			@(posedge aclk);
			if (asm_refused || (tx_valid && tx_ready)) break;
		end
		chk("asm_answer", {asm_refused, tx_valid && tx_ready}, {bad, !bad});
		if (!bad) chk("tx_out", tx_out, {xh, xm});
	endtask
	// Arriving header, then the drop or the indication {extract, qualifier, loss}.
	task automatic rx(input path_hdr_t hh, input logic [3:0] sp, input logic drop,
		input logic [9:0] ex);
		rx_hdr <= hh;
		rx_sap <= sp;
		rx_valid <= 1'b1;
		do @(posedge aclk); while (!rx_ready);
		rx_valid <= 1'b0;
		rx_hdr <= ~hh;
		repeat (40) begin
			@(posedge aclk);
			if (rx_dropped || (ind_valid && ind_ready)) break;
		end
		chk("rx_answer", {rx_dropped, ind_valid && ind_ready}, {drop, !drop});
		if (!drop) chk("ind_out", ind_out, {ex[9], ex[8:1], hh.app_process_ident, ex[0], hh});
	endtask
	// Cuts a hang short.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			num_errors++;
			results();
		end
	end
	// Main sequence.
	initial begin
		seed = 84992;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, asm_valid, rx_valid, slow} = 8'h00;
		{awaddr, araddr, wdata, rx_sap} = 52'h0;
		wstrb = 4'hF;
		asm_req = '0;
		rx_hdr = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("idle", {tx_valid, ind_valid, bvalid, rvalid, asm_ready, rx_ready}, 6'h03);
		rd(`REG_ROUTE, 32'h0, `RESP_OKAY);
		wr(`REG_CTRL, 32'h0, `RESP_OKAY);
		wr(`REG_ROUTE, 32'hF0200123, `RESP_OKAY);
		wr(`REG_SAPS, 32'h00010005, `RESP_OKAY);
		rd(`REG_ROUTE, 32'hF0200123, `RESP_OKAY);
		rd(`REG_SAPS, 32'h00010005, `RESP_OKAY);
		wr(`REG_CTRL, 32'h1, `RESP_OKAY);
		wr(`REG_ROUTE, 32'h800002A5, `RESP_OKAY);
		wr(`REG_SAPS, 32'h2, `RESP_OKAY);
		wr(`REG_CTRL, 32'h2, `RESP_OKAY);
		wr(`REG_ROUTE, 32'h800007F0, `RESP_SLVERR);
		rd(`REG_ROUTE, 32'h0, `RESP_OKAY);
		wr(`REG_ROUTE, 32'h800007EF, `RESP_OKAY);
		wr(8'h10, 32'h1, `RESP_SLVERR);
		rd(8'h10, 32'h0, `RESP_SLVERR);
		wr(`REG_CTRL, 32'h100, `RESP_OKAY);
		// Octet-string packets past the count wrap, with stalls now and then.
		for (int i = 0; i < 16386; i++) begin
			slow <= i[3];
			h = 48'({$random(seed), $random(seed)});
			h.app_process_ident = 11'h123;
			oc = {1'b0, 16'($random(seed))} + 17'h1;
			eh = '{3'h0, 1'b1, h.second_header_present, 11'h123, 2'h3, seq_a[13:0], 16'(oc - 17'h1)};
			asm(h, oc, 1'b0, eh, 16'h0005);
			seq_a = (seq_a + 1) % 16384;
			n_tx++;
		end
		asm(h, 17'h0, 1'b1, h, 16'h0);
		asm(h, 17'h10001, 1'b1, h, 16'h0);
		h.app_process_ident = 11'h055;
		asm(h, 17'h10, 1'b1, h, 16'h0);
		// Packet service keeps every flag code the user gave.
		for (int f = 0; f < 4; f++) begin
			h = 48'({$random(seed), $random(seed)});
			h.app_process_ident = 11'h2A5;
			h.seq_flags = f[1:0];
			eh = h;
			eh.version = 3'h0;
			asm(h, 17'h20, 1'b0, eh, 16'h0002);
			n_tx++;
		end
		h.app_process_ident = 11'h2A5;
		h.type_bit = 1'b1;
		rx(h, 4'h3, 1'b0, 10'h000);
		h.app_process_ident = 11'h123;
		for (int k = 0; k < 5; k++) begin
			h.seq_count = 14'(sq[k]);
			rx(h, 4'h2, 1'b0, {1'b1, 8'h02, k == 2 || k == 3});
			n_loss += (k == 2 || k == 3);
		end
		rx(h, 4'h3, 1'b1, 10'h0);
		h.app_process_ident = 11'h055;
		rx(h, 4'h2, 1'b1, 10'h0);
		rd(`REG_STATUS, {8'h05, 8'(n_loss), 8'(n_tx), 8'h06}, `RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`REG_ROUTE, 32'h0, `RESP_OKAY);
		h.app_process_ident = 11'h123;
		asm(h, 17'h10, 1'b1, h, 16'h0);
		rd(`REG_STATUS, 32'h01000000, `RESP_OKAY);
		wr(`REG_ROUTE, 32'hF0200123, `RESP_OKAY);
		eh = '{3'h0, 1'b0, h.second_header_present, 11'h123, 2'h3, 14'h0, 16'h000F};
		asm(h, 17'h10, 1'b0, eh, 16'h0000);
		results();
	end
endmodule // test_path_packet_framer_router
`default_nettype wire
